// ### logic/adcctl_pkg.sv
// constants and types for the successive-approximation conversion control block
// What this block does
// - one-shot mode: start bit clears itself when the single conversion ends
// - sequential mode: convert back to back until software clears start bit 7
// - channel select write mid-conversion aborts, discards, restarts on new channel
// - reset clears full result to 0000H and high-byte view to 00H
// - result read colliding with conversion end: read first, store after
// - mode/channel/port write at conversion end wins; no store, no interrupt
// - comparator enable bit 0 low powers the comparator down
// - results carry ten bits per sample
`default_nettype none
package adcctl_pkg;
   localparam int unsigned RES_BITS      = 10;
   localparam int unsigned CH_BITS       = 3;
   localparam int unsigned MODE_START    = 7;
   localparam int unsigned MODE_SEQ      = 6;
   localparam int unsigned MODE_CMP_EN   = 0;
   localparam logic [15:0] RESULT_RST    = 16'h0000;
   localparam logic [7:0]  RESULT_H_RST  = 8'h00;
   localparam logic [7:0]  MODE_RST      = 8'h00;
   localparam logic [2:0]  CHAN_RST      = 3'h0;
   // two sample cycles plus one bit per resolution step
   localparam int unsigned SAMPLE_CYCLES = 2;
   typedef enum logic [2:0] {
      ADCCTL_IDLE   = 3'h1,
      ADCCTL_SAMPLE = 3'h2,
      ADCCTL_CONV   = 3'h4
   } adcctl_state_t;
endpackage : adcctl_pkg
`default_nettype wire

// ### logic/adcctl_sar.sv
// successive-approximation bit trial engine
`timescale 1ns/1ps
`default_nettype none
module adcctl_sar #(
   parameter int unsigned WIDTH = 10
) (
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   // control
   input  wire logic             load_i,
   input  wire logic             step_i,
   input  wire logic             cmp_hi_i,
   // trial state
   output logic [WIDTH-1:0]      trial_o,
   output logic                  last_o
);
   logic [WIDTH-1:0] code_r;
   logic [WIDTH-1:0] bit_r;
   logic [WIDTH-1:0] code_nxt;
   logic [WIDTH-1:0] bit_nxt;

   // keep the trial bit when the comparator says input is above, then move down
   assign code_nxt = load_i ? {1'b1, {(WIDTH-1){1'b0}}}
                   : ((cmp_hi_i ? code_r : (code_r & ~bit_r)) | (bit_r >> 1));
   assign bit_nxt  = load_i ? {1'b1, {(WIDTH-1){1'b0}}} : (bit_r >> 1);
   assign trial_o  = code_r;
   assign last_o   = bit_r[0];

   // trial registers
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         code_r <= '0;
         bit_r  <= '0;
      end else if (load_i || step_i) begin
         code_r <= code_nxt;
         bit_r  <= bit_nxt;
      end
   end
endmodule : adcctl_sar
`default_nettype wire

// ### logic/adcctl_top.sv
// conversion control: mode, channel, start/stop, abort and result store
`timescale 1ns/1ps
`default_nettype none
module adcctl_top #(
   parameter int unsigned RES_W = adcctl_pkg::RES_BITS,
   parameter int unsigned CH_W  = adcctl_pkg::CH_BITS
) (
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   // software writes (one-cycle strobes)
   input  wire logic             conv_mode_reg_we_i,
   input  wire logic [7:0]       conv_mode_reg_wdata_i,
   input  wire logic             channel_select_reg_we_i,
   input  wire logic [CH_W-1:0]  channel_select_reg_wdata_i,
   input  wire logic             port_config_reg_we_i,
   // software result read strobe
   input  wire logic             result_rd_i,
   // flag clear from software
   input  wire logic             conv_end_flag_clr_i,
   // comparator from the analog side (asynchronous)
   input  wire logic             cmp_hi_i,
   // control and status
   output logic [7:0]            conv_mode_reg_o,
   output logic [CH_W-1:0]       channel_select_reg_o,
   output logic [15:0]           result_reg_full_o,
   output logic [7:0]            result_reg_high_o,
   output logic                  conv_end_flag_o,
   output logic                  conv_end_irq_o,
   output logic                  busy_o,
   output logic                  comparator_power_o,
   output logic [RES_W-1:0]      trial_code_o
);
   adcctl_pkg::adcctl_state_t state_r, state_nxt;
   logic [7:0]       mode_r;
   logic [CH_W-1:0]  chan_r;
   logic [15:0]      res_r;
   logic [7:0]       resh_r;
   logic             flag_r, irq_r, busy_r, pwr_r;
   logic             cmp_s1_r, cmp_s2_r;
   logic             pend_r;
   logic [RES_W-1:0] pend_val_r;
   logic [1:0]       samp_r;
   logic [RES_W-1:0] trial;
   logic             last;

   // decoded events
   wire cmp_en     = mode_r[adcctl_pkg::MODE_CMP_EN];
   wire start_bit  = mode_r[adcctl_pkg::MODE_START];
   wire seq_mode   = mode_r[adcctl_pkg::MODE_SEQ];
   wire ctl_write  = conv_mode_reg_we_i | channel_select_reg_we_i | port_config_reg_we_i;
   wire in_conv    = (state_r == adcctl_pkg::ADCCTL_CONV);
   wire conv_done  = in_conv && last;
   // final bit decision folded into the completed code
   wire [RES_W-1:0] final_code = cmp_s2_r ? trial : (trial & ~{{(RES_W-1){1'b0}}, 1'b1});
   wire good_end   = conv_done && !ctl_write;
   wire store_now  = good_end && !result_rd_i;
   wire store_pend = pend_r && !result_rd_i;
   wire new_start  = conv_mode_reg_we_i && conv_mode_reg_wdata_i[adcctl_pkg::MODE_START]
                     && conv_mode_reg_wdata_i[adcctl_pkg::MODE_CMP_EN];
   wire run_on     = start_bit && cmp_en;
   wire sar_load   = (state_r == adcctl_pkg::ADCCTL_SAMPLE) && (samp_r == 2'h1);
   // a reselect while sampling reloads the timer so the synchroniser settles on the new input
   wire samp_reload = (state_nxt == adcctl_pkg::ADCCTL_SAMPLE) &&
                      ((state_r != adcctl_pkg::ADCCTL_SAMPLE) || channel_select_reg_we_i);

   adcctl_sar #(.WIDTH(RES_W)) u_sar (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .load_i     (sar_load),
      .step_i     (in_conv),
      .cmp_hi_i   (cmp_s2_r),
      .trial_o    (trial),
      .last_o     (last)
   );

   // state sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         adcctl_pkg::ADCCTL_IDLE: begin
            if (new_start) state_nxt = adcctl_pkg::ADCCTL_SAMPLE;
         end
         adcctl_pkg::ADCCTL_SAMPLE: begin
            if (!run_on) state_nxt = adcctl_pkg::ADCCTL_IDLE;
            else if (channel_select_reg_we_i) state_nxt = adcctl_pkg::ADCCTL_SAMPLE;
            else if (sar_load) state_nxt = adcctl_pkg::ADCCTL_CONV;
         end
         adcctl_pkg::ADCCTL_CONV: begin
            if (channel_select_reg_we_i) state_nxt = adcctl_pkg::ADCCTL_SAMPLE;
            else if (!run_on || (conv_mode_reg_we_i &&
                     !conv_mode_reg_wdata_i[adcctl_pkg::MODE_START]))
               state_nxt = adcctl_pkg::ADCCTL_IDLE;
            else if (conv_done && seq_mode) state_nxt = adcctl_pkg::ADCCTL_SAMPLE;
            else if (conv_done) state_nxt = adcctl_pkg::ADCCTL_IDLE;
         end
         default: state_nxt = adcctl_pkg::ADCCTL_IDLE;
      endcase
   end

   // comparator synchroniser: second stage only is read
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmp_s1_r <= 1'b0;
         cmp_s2_r <= 1'b0;
      end else begin
         cmp_s1_r <= cmp_hi_i;
         cmp_s2_r <= cmp_s1_r;
      end
   end

   // state, sample timer
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= adcctl_pkg::ADCCTL_IDLE;
         samp_r  <= 2'h0;
      end else begin
         state_r <= state_nxt;
         samp_r  <= samp_reload ? 2'(adcctl_pkg::SAMPLE_CYCLES)
                    : (samp_r != 2'h0 ? samp_r - 2'h1 : 2'h0);
      end
   end

   // mode and channel registers
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_r <= adcctl_pkg::MODE_RST;
         chan_r <= adcctl_pkg::CHAN_RST;
      end else begin
         if (conv_mode_reg_we_i) mode_r <= conv_mode_reg_wdata_i;
         else if (good_end && !seq_mode) mode_r[adcctl_pkg::MODE_START] <= 1'b0;
         if (channel_select_reg_we_i) chan_r <= channel_select_reg_wdata_i;
      end
   end

   // result store, reset values, ten bits, deferred store
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         res_r      <= adcctl_pkg::RESULT_RST;
         resh_r     <= adcctl_pkg::RESULT_H_RST;
         pend_r     <= 1'b0;
         pend_val_r <= '0;
      end else begin
         if (store_now || store_pend) begin
            res_r  <= {(store_now ? final_code : pend_val_r), 6'h00};
            resh_r <= (store_now ? final_code[RES_W-1 -: 8] : pend_val_r[RES_W-1 -: 8]);
         end
         pend_r <= (good_end && result_rd_i) || (pend_r && result_rd_i);
         if (good_end && result_rd_i) pend_val_r <= final_code;
      end
   end

   // flag and interrupt; set beats clear
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_r <= 1'b0;
         irq_r  <= 1'b0;
         busy_r <= 1'b0;
         pwr_r  <= 1'b0;
      end else begin
         flag_r <= good_end | (flag_r & ~conv_end_flag_clr_i);
         irq_r  <= good_end;
         busy_r <= (state_nxt != adcctl_pkg::ADCCTL_IDLE);
         pwr_r  <= conv_mode_reg_we_i ? conv_mode_reg_wdata_i[adcctl_pkg::MODE_CMP_EN] : cmp_en;
      end
   end

   assign conv_mode_reg_o      = mode_r;
   assign channel_select_reg_o = chan_r;
   assign result_reg_full_o    = res_r;
   assign result_reg_high_o    = resh_r;
   assign conv_end_flag_o      = flag_r;
   assign conv_end_irq_o       = irq_r;
   assign busy_o               = busy_r;
   assign comparator_power_o   = pwr_r;
   assign trial_code_o         = trial;

   a_irq_sets_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      irq_r |-> flag_r) else $error("irq without flag");
   a_flag_set_wins: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      good_end |=> flag_r) else $error("flag not set at conversion end");
   a_oneshot_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (good_end && !seq_mode && !conv_mode_reg_we_i) |=> !mode_r[adcctl_pkg::MODE_START])
      else $error("start bit stayed set");
   a_write_blocks_irq: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (conv_done && ctl_write) |=> !irq_r) else $error("irq despite write");
   a_write_blocks_store: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (conv_done && ctl_write && !pend_r) |=> $stable(res_r))
      else $error("store despite write");
   a_reselect_abort: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (in_conv && channel_select_reg_we_i) |=> state_r == adcctl_pkg::ADCCTL_SAMPLE)
      else $error("no restart on reselect");
   a_read_defers: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (good_end && result_rd_i) |=> $stable(res_r)) else $error("store during read");
   a_pend_store: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (pend_r && !result_rd_i && !good_end) |=> res_r[15 -: RES_W] == $past(pend_val_r))
      else $error("deferred result lost");
   a_seq_continue: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (conv_done && seq_mode && run_on && !ctl_write) |=> state_r == adcctl_pkg::ADCCTL_SAMPLE)
      else $error("sequential stopped");
   a_stop_to_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (in_conv && conv_mode_reg_we_i && !conv_mode_reg_wdata_i[adcctl_pkg::MODE_START]
       && !channel_select_reg_we_i) |=> state_r == adcctl_pkg::ADCCTL_IDLE)
      else $error("converter kept running");
   a_power_follows: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      conv_mode_reg_we_i |=> pwr_r == $past(conv_mode_reg_wdata_i[adcctl_pkg::MODE_CMP_EN]))
      else $error("power mismatch");
   a_start_needs_en: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_r == adcctl_pkg::ADCCTL_IDLE && new_start) |=> busy_r)
      else $error("start ignored");
   a_low_bits_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      res_r[5:0] == 6'h00) else $error("result low bits set");
   // main scenarios reached
   c_oneshot: cover property (@(posedge core_clk_i) good_end && !seq_mode);
   c_seq: cover property (@(posedge core_clk_i) good_end && seq_mode);
   c_abort: cover property (@(posedge core_clk_i) in_conv && channel_select_reg_we_i);
   c_read_clash: cover property (@(posedge core_clk_i) good_end && result_rd_i);
   c_write_clash: cover property (@(posedge core_clk_i) conv_done && ctl_write);
endmodule : adcctl_top
`default_nettype wire

// ### tb/adcctl_ana.sv
// analog side model: per-channel input level compared against the trial code
`timescale 1ns/1ps
`default_nettype none
module adcctl_ana (
   // selection and trial from the block
   input  wire logic [2:0] chan_i,
   input  wire logic [9:0] trial_i,
   // comparator decision
   output logic            cmp_hi_o
);
   // even channels sit above full scale, odd ones at ground, so synchroniser lag cannot move codes
   // pins stay analog: the model never changes a channel's function mid-conversion
   // one fixed full-scale reference; the internal reference is never selected here
   assign cmp_hi_o = ({1'b0, trial_i} < (chan_i[0] ? 11'h000 : 11'h400));
endmodule : adcctl_ana
`default_nettype wire

// ### tb/adcctl_top_tb.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module adcctl_top_tb;
   logic        clk, rst_n, mode_we, ch_we, pc_we, rd, clr;
   logic [7:0]  wdata;
   logic [2:0]  ch;
   wire logic   cmp, flag, irq, busy, pwr;
   wire logic [7:0]  mode, res_h;
   wire logic [2:0]  ch_o;
   wire logic [15:0] res;
   wire logic [9:0]  trial;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   logic [7:0]  seed;
   int          failures, checks_done, cyc, n, lat;

   adcctl_top uut (.core_clk_i(clk), .rst_n_i(rst_n), .conv_mode_reg_we_i(mode_we),
      .conv_mode_reg_wdata_i(wdata), .channel_select_reg_we_i(ch_we),
      .channel_select_reg_wdata_i(ch), .port_config_reg_we_i(pc_we), .result_rd_i(rd),
      .conv_end_flag_clr_i(clr), .cmp_hi_i(cmp), .conv_mode_reg_o(mode),
      .channel_select_reg_o(ch_o), .result_reg_full_o(res), .result_reg_high_o(res_h),
      .conv_end_flag_o(flag), .conv_end_irq_o(irq), .busy_o(busy),
      .comparator_power_o(pwr), .trial_code_o(trial));
   adcctl_ana ana (.chan_i(ch_o), .trial_i(trial), .cmp_hi_o(cmp));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         failures++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask : chk

   // one-cycle write strobe: 0 mode, 1 channel, 2 port config
   task automatic wr(input int which, input logic [7:0] v);
      @(posedge clk);
      mode_we <= (which == 0);
      ch_we   <= (which == 1);
      pc_we   <= (which == 2);
      wdata   <= v;
      ch      <= v[2:0];
      @(posedge clk);
      mode_we <= 1'b0;
      ch_we   <= 1'b0;
      pc_we   <= 1'b0;
   endtask : wr

   // bounded wait for the end pulse, n counts edges
   task automatic wait_irq();
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (irq !== 1'b1 && n < 100);
      chk(irq === 1'b1, "no conversion end");
   endtask : wait_irq

   task automatic clr_flag();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask : clr_flag

   task automatic summarize();
      $display("failures=%0d checks_done=%0d", failures, checks_done);
      if (failures == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   // scoreboard: every end pulse takes the oldest note; a late look covers a deferred store
   always @(posedge clk) begin
      #1;
      if (irq === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(1'b0, "unexpected conversion end");
         end else begin
            e = exp_q.pop_front();
            repeat (3) @(posedge clk);
            #1;
            chk(res === e, "result value");
            chk(res_h === e[15:8], "high byte view");
         end
      end
   end

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         summarize();
      end
   end

   initial begin
      {rst_n, mode_we, ch_we, pc_we, rd, clr, wdata, ch} = '0;
      seed = 8'h0e;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk(res === 16'h0000 && res_h === 8'h00, "reset result");
      wr(0, 8'h80);
      repeat (20) @(posedge clk);
      #1;
      chk(busy === 1'b0, "start without comparator");
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         wr(1, {5'h00, seed[2:0]});
         exp_q.push_back(seed[0] ? 16'h0000 : 16'hffc0);
         wr(0, 8'h81);
         wait_irq();
         if (i == 0) lat = n;
         chk(mode[7] === 1'b0 && flag === 1'b1 && pwr === 1'b1, "one-shot end");
         chk(trial === (seed[0] ? 10'h000 : 10'h3ff), "final trial code");
         chk(ch_o === seed[2:0], "channel register");
         // flag cleared before the next start
         clr_flag();
         repeat (4) @(posedge clk);
      end
      wr(0, 8'h00);
      @(posedge clk);
      #1;
      chk(pwr === 1'b0, "comparator power down");
      wr(1, 8'h00);
      repeat (3) exp_q.push_back(16'hffc0);
      wr(0, 8'hc1);
      repeat (3) wait_irq();
      chk(mode[7] === 1'b1, "sequential keeps running");
      // let the stop land inside the bit trials, not in the sample phase
      repeat (4) @(posedge clk);
      wr(0, 8'h01);
      repeat (30) @(posedge clk);
      #1;
      chk(busy === 1'b0, "sequential stop");
      clr_flag();
      exp_q.push_back(16'h0000);
      wr(0, 8'h81);
      repeat (4) @(posedge clk);
      wr(1, 8'h01);
      wait_irq();
      clr_flag();
      repeat (6) @(posedge clk);
      wr(1, 8'h00);
      wr(0, 8'h81);
      repeat (lat - 1) @(posedge clk);
      pc_we <= 1'b1;
      @(posedge clk);
      pc_we <= 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk(res === 16'h0000 && flag === 1'b0, "write at conversion end");
      wr(0, 8'h01);
      exp_q.push_back(16'hffc0);
      wr(0, 8'h81);
      repeat (lat - 1) @(posedge clk);
      rd <= 1'b1;
      @(posedge clk);
      #1;
      chk(res === 16'h0000, "read before store");
      @(posedge clk);
      rd <= 1'b0;
      repeat (20) @(posedge clk);
      // reset in mid-run clears a stored result and the flag
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk(res === 16'h0000 && res_h === 8'h00 && flag === 1'b0, "mid-run reset");
      summarize();
   end
endmodule : adcctl_top_tb
`default_nettype wire
